// *** include/alu_ops_pkg.sv ***
// Package with opcodes, field positions and types of the instruction executor.
package alu_ops_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int DEST_BIT = 7;
  localparam int FILE_LSB = 0;
  localparam int LIT_LSB = 0;
  localparam int OPC_LSB = 8;
  localparam int MOVLIT_LSB = 10;
  localparam int STORE_LSB = 7;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [5:0] OPC_DEC_SKIP_VAL = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP_VAL = 6'h0f;
  localparam logic [5:0] OPC_ORREG_VAL = 6'h04;
  localparam logic [5:0] OPC_ORLIT_VAL = 6'h38;
  localparam logic [6:0] OPC_STORE_VAL = 7'h01;
  localparam logic [3:0] OPC_MOVLIT_VAL = 4'hc;
  localparam logic [1:0] MOVLIT_DC_ZERO = 2'h0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DEC_SKIP = 3'b001,
    OP_INC_SKIP = 3'b010,
    OP_OR_REG = 3'b011,
    OP_OR_LIT = 3'b100,
    OP_MOVE_LIT = 3'b101,
    OP_STORE = 3'b110
  } op_t;

  typedef struct packed {
    op_t op;
    logic dest_file;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } decoded_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_t;
endpackage

// *** core/op_decoder.sv ***
// Decoder from a 14-bit instruction word to an operation and its operands.
`timescale 1ns/10ps
module op_decoder
  import alu_ops_pkg::*;
(
  input wire logic [INSTR_W-1:0] i_instr,
  output decoded_t o_dec
);
  always_comb begin
    o_dec.op = OP_NONE;
    o_dec.dest_file = i_instr[DEST_BIT];
    o_dec.addr = i_instr[FILE_LSB +: ADDR_W];
    o_dec.lit = i_instr[LIT_LSB +: DATA_W];
    if (i_instr[INSTR_W-1:OPC_LSB] == OPC_DEC_SKIP_VAL) begin
      o_dec.op = OP_DEC_SKIP;
    end else if (i_instr[INSTR_W-1:OPC_LSB] == OPC_INC_SKIP_VAL) begin
      o_dec.op = OP_INC_SKIP;
    end else if (i_instr[INSTR_W-1:OPC_LSB] == OPC_ORREG_VAL) begin
      o_dec.op = OP_OR_REG;
    end else if (i_instr[INSTR_W-1:OPC_LSB] == OPC_ORLIT_VAL) begin
      o_dec.op = OP_OR_LIT;
    end else if (i_instr[INSTR_W-1:MOVLIT_LSB] == OPC_MOVLIT_VAL) begin
      // Don't-care bits 9:8 are ignored here; the assembler emits zeros.
      o_dec.op = OP_MOVE_LIT;
    end else if (i_instr[INSTR_W-1:STORE_LSB] == OPC_STORE_VAL) begin
      o_dec.op = OP_STORE;
    end
  end
endmodule

// *** core/alu_skip_move_core.sv ***
// Executor for skip-on-zero, OR and move operations of the CPU core.
//
// Contract
// - decrement file, write to working or file; zero result skips next.
// - increment file, write to destination; zero result skips next.
// - OR working with file; destination bit picks working or file.
// - OR working with 8-bit literal into working, zero flag updated.
// - load literal into working, flags untouched, don't-cares are zero.
// - store working into file at 7-bit address, flags untouched.
`timescale 1ns/10ps
module alu_skip_move_core
  import alu_ops_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [DATA_W-1:0] i_file_rdata,
  output logic [ADDR_W-1:0] o_file_raddr,
  output file_write_t o_file_wr,
  output logic [DATA_W-1:0] o_wreg,
  output logic o_zero,
  output logic o_skip_active,
  output logic o_done
);
  decoded_t dec;
  logic skip_now;
  logic [DATA_W-1:0] result;
  logic to_file;
  logic to_wreg;
  logic sets_zero;
  logic take_skip;
  logic exec;
  logic commit;
  logic result_zero;
  logic [DATA_W-1:0] next_wreg;
  logic next_zero;
  logic next_skip;
  file_write_t next_file_wr;
  logic next_done;
  logic [ADDR_W-1:0] next_raddr;

  op_decoder u_dec (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  // The file read address comes straight from the instruction word, so the
  // file data arrives in the same instruction cycle; o_file_raddr is only a
  // registered copy kept for observation.
  assign exec = i_ce && i_instr_valid;

  // A skipped slot executes as a no-op: the word in it has no effect.
  assign skip_now = o_skip_active;
  assign commit = exec && !skip_now;

  // Data path: the value that each operation produces.
  always_comb begin
    result = i_file_rdata;
    unique case (dec.op)
      OP_DEC_SKIP: begin
        result = i_file_rdata - 8'h01;
      end
      OP_INC_SKIP: begin
        result = i_file_rdata + 8'h01;
      end
      OP_OR_REG: begin
        result = o_wreg | i_file_rdata;
      end
      OP_OR_LIT: begin
        result = o_wreg | dec.lit;
      end
      OP_MOVE_LIT: begin
        result = dec.lit;
      end
      OP_STORE: begin
        result = o_wreg;
      end
      OP_NONE: begin
        result = i_file_rdata;
      end
    endcase
  end

  // One zero test feeds both the skip decision and the zero flag, so the
  // two can never disagree on what counts as a zero result.
  assign result_zero = (result == 8'h00);

  // Routing: where the result goes and which side effects it has.
  always_comb begin
    to_file = 1'b0;
    to_wreg = 1'b0;
    sets_zero = 1'b0;
    take_skip = 1'b0;
    unique case (dec.op)
      OP_DEC_SKIP: begin
        to_file = dec.dest_file;
        to_wreg = !dec.dest_file;
        take_skip = result_zero;
      end
      OP_INC_SKIP: begin
        to_file = dec.dest_file;
        to_wreg = !dec.dest_file;
        take_skip = result_zero;
      end
      OP_OR_REG: begin
        to_file = dec.dest_file;
        to_wreg = !dec.dest_file;
        sets_zero = 1'b1;
      end
      OP_OR_LIT: begin
        to_wreg = 1'b1;
        sets_zero = 1'b1;
      end
      OP_MOVE_LIT: begin
        to_wreg = 1'b1;
      end
      OP_STORE: begin
        to_file = 1'b1;
      end
      OP_NONE: begin
        // Unknown words decode here and act as no-ops.
        to_wreg = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (commit && to_wreg) begin
      next_wreg = result;
    end else begin
      next_wreg = o_wreg;
    end
  end

  // Only the OR operations move the flag; skips, moves and stores keep it.
  always_comb begin
    if (commit && sets_zero) begin
      next_zero = result_zero;
    end else begin
      next_zero = o_zero;
    end
  end

  // Address and data follow every enabled cycle; only wr tells the register
  // file to take them, which keeps the write port free of extra muxing.
  always_comb begin
    next_file_wr.wr = commit && to_file;
    next_file_wr.addr = dec.addr;
    next_file_wr.data = result;
  end

  // Skip state lasts exactly the following instruction cycle, giving the
  // skipping operation its two-cycle length. The word in the skipped slot
  // clears it even if that word would skip too, so skips never chain.
  always_comb begin
    if (exec) begin
      next_skip = !skip_now && take_skip;
    end else begin
      next_skip = o_skip_active;
    end
  end

  // Skipped words still count as taken, so o_done marks every instruction
  // cycle that the fetch side spent.
  always_comb begin
    next_done = exec;
    next_raddr = dec.addr;
  end

  // Every register below holds while i_ce is low, so a stalled fetch side
  // can freeze the core without losing a pending skip.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_wreg <= WREG_RESET;
    end else if (i_ce) begin
      o_wreg <= next_wreg;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_zero <= ZERO_RESET;
    end else if (i_ce) begin
      o_zero <= next_zero;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_file_wr <= '0;
    end else if (i_ce) begin
      o_file_wr <= next_file_wr;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_skip_active <= 1'b0;
    end else if (i_ce) begin
      o_skip_active <= next_skip;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= next_done;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_file_raddr <= '0;
    end else if (i_ce) begin
      o_file_raddr <= next_raddr;
    end
  end
endmodule

// *** tb/alu_skip_move_chk.sv ***
// Checker of the executor's port behaviour.
`timescale 1ns/10ps
module alu_skip_move_chk
  import alu_ops_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [DATA_W-1:0] i_file_rdata,
  input wire file_write_t o_file_wr,
  input wire logic [DATA_W-1:0] o_wreg,
  input wire logic o_zero,
  input wire logic o_skip_active
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  // A word in a skipped slot must not execute, so it is left out here.
  wire t = i_ce && i_instr_valid && !o_skip_active;
  wire s = i_ce && i_instr_valid && o_skip_active;
  wire [5:0] op = i_instr[13:8];
  wire [7:0] dm = i_file_rdata - 8'h01, ip = i_file_rdata + 8'h01;
  wire [7:0] orv = o_wreg | i_file_rdata, olv = o_wreg | i_instr[7:0];
  a_dec_skip: assert property (t && op == 6'h0b |=>
    o_skip_active == ($past(dm) == 8'h00)) else $error("Bad skip.");
  a_dec_write: assert property (t && op == 6'h0b && i_instr[7] |=>
    o_file_wr.wr && o_file_wr.data == $past(dm)) else $error("Bad write.");
  a_inc_skip: assert property (t && op == 6'h0f |=>
    o_skip_active == ($past(ip) == 8'h00)) else $error("Bad skip.");
  a_skip_zf: assert property (t && (op == 6'h0b || op == 6'h0f) |=>
    $stable(o_zero)) else $error("Flag moved.");
  a_or_reg: assert property (t && op == 6'h04 |=>
    o_file_wr.wr == $past(i_instr[7]) && o_zero == ($past(orv) == 8'h00))
    else $error("Bad OR.");
  a_or_lit: assert property (t && op == 6'h38 |=>
    o_wreg == $past(olv) && o_zero == (o_wreg == 8'h00))
    else $error("Bad OR.");
  a_move_lit: assert property (t && i_instr[13:10] == 4'hc |=>
    o_wreg == $past(i_instr[7:0]) && $stable(o_zero))
    else $error("Bad move.");
  a_store_op: assert property (t && i_instr[13:7] == 7'h01 |=>
    o_file_wr.wr && o_file_wr.data == $past(o_wreg) && $stable(o_zero))
    else $error("Bad store.");
  a_skip_slot: assert property (s |=> !o_skip_active &&
    !o_file_wr.wr && $stable(o_wreg) && $stable(o_zero))
    else $error("Skipped word ran.");
endmodule
bind alu_skip_move_core alu_skip_move_chk u_alu_skip_move_chk (.I_CLK_SYS,
  .I_ARST_N, .i_ce, .i_instr_valid, .i_instr, .i_file_rdata, .o_file_wr,
  .o_wreg, .o_zero, .o_skip_active);

// *** tb/cpu_alu_skip_and_move_ops_tb.sv ***
// Bench that runs the executor through OR, move and skip sequences.
`timescale 1ns/10ps
module cpu_alu_skip_and_move_ops_tb;
  import alu_ops_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, vld = 1'b0, z, sk, dn;
  logic [6:0] ra;
  logic [13:0] ins = 14'h0000;
  logic [7:0] rd = 8'h00, w;
  file_write_t fw;
  int fail_count = 0, check_count = 0;
  alu_skip_move_core u_alu_skip_move_core (.I_CLK_SYS(clk), .I_ARST_N(rst_n),
    .i_ce(ce), .i_instr_valid(vld), .i_instr(ins), .i_file_rdata(rd),
    .o_file_raddr(ra), .o_file_wr(fw), .o_wreg(w), .o_zero(z),
    .o_skip_active(sk), .o_done(dn));
  task cmp(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task ex(input logic [13:0] i, input logic [7:0] r, ew, input logic ez, es);
    {ins, rd} = {i, r};
    @(negedge clk);
    cmp(w, ew);
    cmp({6'h00, z, sk}, {6'h00, ez, es});
    cmp({dn, ra}, {1'b1, i[6:0]});
  endtask
  task t_or_move;
    ex({4'hc, 2'h3, 8'h00}, 8'h00, 8'h00, 1'b0, 1'b0);
    ex({6'h38, 8'h00}, 8'h00, 8'h00, 1'b1, 1'b0);
    ex({4'hc, 2'h0, 8'h7e}, 8'h00, 8'h7e, 1'b1, 1'b0);
    ex({7'h01, 7'h7f}, 8'h00, 8'h7e, 1'b1, 1'b0);
    cmp({fw.wr, fw.addr}, 8'hff);
    cmp(fw.data, 8'h7e);
    ex({6'h04, 8'h85}, 8'h81, 8'h7e, 1'b0, 1'b0);
    cmp(fw.data, 8'hff);
    ex({6'h04, 8'h05}, 8'h00, 8'h7e, 1'b0, 1'b0);
  endtask
  task t_skip;
    ex({6'h0b, 8'h83}, 8'h01, 8'h7e, 1'b0, 1'b1);
    cmp(fw.data, 8'h00);
    ex({4'hc, 2'h0, 8'h55}, 8'h00, 8'h7e, 1'b0, 1'b0);
    ex({6'h0f, 8'h03}, 8'hff, 8'h00, 1'b0, 1'b1);
    ex({6'h38, 8'h0f}, 8'h00, 8'h00, 1'b0, 1'b0);
    ex({6'h0b, 8'h03}, 8'h02, 8'h01, 1'b0, 1'b0);
  endtask
  task t_edges;
    {ce, ins, rd} = {1'b0, 6'h38, 8'h80, 8'h00};
    repeat (2) @(negedge clk);
    cmp(w, 8'h01);
    cmp({6'h00, z, sk}, 8'h00);
    ce = 1'b1;
    ex({6'h38, 8'h80}, 8'h00, 8'h81, 1'b0, 1'b0);
    ex(14'h0000, 8'hff, 8'h81, 1'b0, 1'b0);
    cmp({fw.wr, fw.addr}, 8'h00);
    ex({6'h0f, 8'h84}, 8'hff, 8'h81, 1'b0, 1'b1);
    cmp(fw.data, 8'h00);
    ex({6'h0b, 8'h05}, 8'h01, 8'h81, 1'b0, 1'b0);
    cmp({fw.wr, fw.addr}, 8'h05);
    ex({6'h0f, 8'h05}, 8'h10, 8'h11, 1'b0, 1'b0);
    ex({4'hc, 2'h0, 8'h00}, 8'h00, 8'h00, 1'b0, 1'b0);
    ex({6'h38, 8'h00}, 8'h00, 8'h00, 1'b1, 1'b0);
    ex({6'h0b, 8'h06}, 8'h05, 8'h04, 1'b1, 1'b0);
  endtask
  task end_of_test;
    $display("Checks %0d, errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    // Valid stays high so every word follows its predecessor back to back.
    vld = 1'b1;
    t_or_move;
    t_skip;
    t_edges;
    end_of_test;
  end
endmodule
